// *** src/lcs_consts.svh ***
`ifndef LCS_CONSTS_SVH
`define LCS_CONSTS_SVH

// Datapath widths and sense limits
`define LCS_SENSE_W 10
`define LCS_OFS_W 6
`define LCS_SENSE_MAX 10'h3FF
`define LCS_SENSE_ZERO 10'h000

// Sense-select encoding, {sense_select_bit1, sense_select_bit0}
`define LCS_SEL_OFF 2'h0
`define LCS_SEL_CH0 2'h1
`define LCS_SEL_CH1 2'h2
`define LCS_SEL_TEMP 2'h3

// Configuration reset values
`define LCS_RST_SEL 2'h0
`define LCS_RST_HOLD_MODE 1'h0
`define LCS_RST_RATIO_LOW 1'h0
`define LCS_RST_OFS_POL 2'h0

// Settling time of the sense mirror after turn-on
`define LCS_CLK_MHZ 250
`define LCS_SETTLE_NS 2000
`define LCS_SETTLE_CYC ((`LCS_SETTLE_NS * `LCS_CLK_MHZ + 999) / 1000)
`define LCS_SETTLE_CW 10

`endif

// *** src/lcs_pkg.sv ***
`default_nettype none
`include "lcs_consts.svh"

package lcs_pkg;

    typedef enum logic [1:0] {
        LCS_ST_IDLE,
        LCS_ST_SETTLE,
        LCS_ST_VALID,
        LCS_ST_HOLD
    } lcs_state_t;

    typedef enum logic [1:0] {
        LCS_SRC_NONE,
        LCS_SRC_CH0,
        LCS_SRC_CH1,
        LCS_SRC_TEMP
    } lcs_src_t;

    typedef struct packed {
        logic sense_select_bit1;
        logic sense_select_bit0;
        logic hold_mode;
        logic ratio_low;
        logic [1:0] offset_polarity;
    } lcs_cfg_t;

    typedef struct packed {
        lcs_state_t state;
        lcs_cfg_t cfg;
        lcs_src_t src_prev;
        logic [`LCS_SENSE_W-1:0] held;
        logic [`LCS_SENSE_W-1:0] sense_out;
        logic strobe_n;
        logic accurate;
    } lcs_regs_t;

    typedef struct packed {
        logic [`LCS_SETTLE_CW-1:0] cnt;
        logic done;
    } lcs_settle_regs_t;

endpackage : lcs_pkg

`default_nettype wire

// *** src/lcs_settle.sv ***
`default_nettype none
`include "lcs_consts.svh"

module lcs_settle
    import lcs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Timer control
    input wire logic run,
    output logic done
);

    localparam logic [`LCS_SETTLE_CW-1:0] LAST = `LCS_SETTLE_CW'(`LCS_SETTLE_CYC - 1);

    lcs_settle_regs_t r;
    lcs_settle_regs_t next_r;

    // Restarts whenever run drops, so a glitch in the on-phase re-times settling
    always_comb begin
        next_r = r;
        if (!run) begin
            next_r.cnt = '0;
            next_r.done = 1'b0;
        end else if (r.cnt == LAST) begin
            next_r.done = 1'b1;
        end else begin
            next_r.cnt = r.cnt + `LCS_SETTLE_CW'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign done = r.done;

endmodule : lcs_settle

`default_nettype wire

// *** src/lcs_sense_ctrl.sv ***
`default_nettype none
`include "lcs_consts.svh"

// Operation
// - Route channel current or temperature per select
// - Overcurrent window: sensing off, strobe high
// - Hold-mode bit 0 synchronous, 1 track-and-hold
// - Hold-mode bit resets to synchronous
// - Ratio bit picks mirror, lowers thresholds
// - Sync mode: strobe low after settling until off
// - Sync mode: no current output when off
// - Track-and-hold: capture at off, present held
// - Track-and-hold: strobe high at capture
// - Track-and-hold accurate after strobe falling edge
// - Channel change discards held value first
// - Offset polarity adds or subtracts offset
// - Held value keeps polarity used at capture
module lcs_sense_ctrl
    import lcs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Configuration write port
    input wire logic cfg_wr,
    input wire lcs_cfg_t cfg_wdata,
    output lcs_cfg_t cfg_rdata,
    // Channel state from switch control
    input wire logic [1:0] chan_on,
    input wire logic [1:0] oc_window,
    // Digitised mirror and temperature values
    input wire logic [`LCS_SENSE_W-1:0] cur0,
    input wire logic [`LCS_SENSE_W-1:0] cur1,
    input wire logic [`LCS_SENSE_W-1:0] temp_code,
    input wire logic [`LCS_OFS_W-1:0] rand_ofs0,
    input wire logic [`LCS_OFS_W-1:0] rand_ofs1,
    // Sense output side
    output logic [`LCS_SENSE_W-1:0] sense_out,
    output lcs_src_t sense_src,
    output logic sense_accurate,
    output logic sense_valid_strobe_n,
    // Analog trims
    output logic ratio_low_sel,
    output logic [1:0] oc_threshold_low
);

    localparam int SETTLE_CYC = `LCS_SETTLE_CYC;

    function automatic lcs_src_t lcs_decode_src(input lcs_cfg_t c);
        unique case ({c.sense_select_bit1, c.sense_select_bit0})
            `LCS_SEL_CH0: lcs_decode_src = LCS_SRC_CH0;
            `LCS_SEL_CH1: lcs_decode_src = LCS_SRC_CH1;
            `LCS_SEL_TEMP: lcs_decode_src = LCS_SRC_TEMP;
            default: lcs_decode_src = LCS_SRC_NONE;
        endcase
    endfunction : lcs_decode_src

    // Saturating, so a large negative offset never wraps to full scale
    function automatic logic [`LCS_SENSE_W-1:0] lcs_apply_offset(
        input logic [`LCS_SENSE_W-1:0] v,
        input logic [`LCS_OFS_W-1:0] o,
        input logic pol
    );
        logic [`LCS_SENSE_W:0] s;
        logic [`LCS_SENSE_W-1:0] oe;
        oe = {{(`LCS_SENSE_W-`LCS_OFS_W){1'b0}}, o};
        s = {1'b0, v} + {1'b0, oe};
        if (pol) begin
            lcs_apply_offset = s[`LCS_SENSE_W] ? `LCS_SENSE_MAX : s[`LCS_SENSE_W-1:0];
        end else begin
            lcs_apply_offset = (v >= oe) ? (v - oe) : `LCS_SENSE_ZERO;
        end
    endfunction : lcs_apply_offset

    lcs_regs_t r;
    lcs_regs_t next_r;
    lcs_cfg_t cfg_now;
    lcs_src_t src;
    logic ch;
    logic is_cur;
    logic on;
    logic oc;
    logic chg;
    logic [`LCS_SENSE_W-1:0] raw;
    logic [`LCS_OFS_W-1:0] ofs;
    logic [`LCS_SENSE_W-1:0] live;
    logic settle_done;

    lcs_settle i_lcs_settle (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(r.state == LCS_ST_SETTLE),
        .done(settle_done)
    );

    always_comb begin
        cfg_now = cfg_wr ? cfg_wdata : r.cfg;
        src = lcs_decode_src(cfg_now);
        ch = (src == LCS_SRC_CH1);
        is_cur = (src == LCS_SRC_CH0) || (src == LCS_SRC_CH1);
        on = chan_on[ch];
        oc = oc_window[ch];
        chg = (src != r.src_prev);
        raw = ch ? cur1 : cur0;
        ofs = ch ? rand_ofs1 : rand_ofs0;
        live = lcs_apply_offset(raw, ofs, cfg_now.offset_polarity[ch]);

        next_r = r;
        next_r.cfg = cfg_now;
        next_r.src_prev = src;
        unique case (r.state)
            LCS_ST_IDLE: begin
                if (on) begin
                    next_r.state = LCS_ST_SETTLE;
                end
            end
            LCS_ST_SETTLE: begin
                if (!on) begin
                    next_r.state = LCS_ST_IDLE;
                end else if (settle_done) begin
                    next_r.state = LCS_ST_VALID;
                end
            end
            LCS_ST_VALID: begin
                if (!on && cfg_now.hold_mode) begin
                    next_r.state = LCS_ST_HOLD;
                    next_r.held = live;
                end else if (!on) begin
                    next_r.state = LCS_ST_IDLE;
                end
            end
            LCS_ST_HOLD: begin
                if (!cfg_now.hold_mode) begin
                    next_r.state = LCS_ST_IDLE;
                end else if (on) begin
                    next_r.state = LCS_ST_SETTLE;
                end
            end
        endcase
        // A new source empties the hold first; an off channel has nothing to reacquire
        if (!is_cur || chg) begin
            next_r.state = LCS_ST_IDLE;
            next_r.held = `LCS_SENSE_ZERO;
        end else if (oc) begin
            next_r.state = LCS_ST_IDLE;
        end

        if (src == LCS_SRC_TEMP) begin
            next_r.sense_out = temp_code;
        end else if (!is_cur || oc) begin
            next_r.sense_out = `LCS_SENSE_ZERO;
        end else if (next_r.state == LCS_ST_HOLD) begin
            next_r.sense_out = next_r.held;
        end else if (on && !chg) begin
            next_r.sense_out = live;
        end else begin
            next_r.sense_out = `LCS_SENSE_ZERO;
        end
        next_r.strobe_n = (next_r.state != LCS_ST_VALID);
        next_r.accurate = (next_r.state == LCS_ST_VALID) ||
                          (next_r.state == LCS_ST_HOLD);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            r.state <= LCS_ST_IDLE;
            r.cfg.sense_select_bit1 <= 1'(`LCS_RST_SEL >> 1);
            r.cfg.sense_select_bit0 <= 1'(`LCS_RST_SEL);
            r.cfg.hold_mode <= `LCS_RST_HOLD_MODE;
            r.cfg.ratio_low <= `LCS_RST_RATIO_LOW;
            r.cfg.offset_polarity <= `LCS_RST_OFS_POL;
            r.src_prev <= LCS_SRC_NONE;
            r.held <= `LCS_SENSE_ZERO;
            r.sense_out <= `LCS_SENSE_ZERO;
            r.strobe_n <= 1'b1;
            r.accurate <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign cfg_rdata = r.cfg;
    assign sense_out = r.sense_out;
    assign sense_src = r.src_prev;
    assign sense_accurate = r.accurate;
    assign sense_valid_strobe_n = r.strobe_n;
    assign ratio_low_sel = r.cfg.ratio_low;
    assign oc_threshold_low = {2{r.cfg.ratio_low}};

    // Helper logic for the checks below
    int settle_age;
    logic [`LCS_SENSE_W:0] sum_chk;
    always_ff @(posedge core_clk) begin
        if (!rst_n || r.state != LCS_ST_SETTLE) begin
            settle_age <= 0;
        end else begin
            settle_age <= settle_age + 1;
        end
    end
    assign sum_chk = {1'b0, raw} + {{(`LCS_SENSE_W+1-`LCS_OFS_W){1'b0}}, ofs};

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_steady_cur;
        is_cur && on && !oc && !chg;
    endsequence
    sequence s_valid_off;
        r.state == LCS_ST_VALID && is_cur && !on && !oc && !chg;
    endsequence
    sequence s_hold_two;
        r.state == LCS_ST_HOLD ##1 r.state == LCS_ST_HOLD;
    endsequence

    a_temp_route: assert property (
        src == LCS_SRC_TEMP |=> sense_out == $past(temp_code) && sense_src == LCS_SRC_TEMP)
        else $error("temperature not routed");
    a_oc_blocks: assert property (
        is_cur && oc |=> sense_valid_strobe_n && sense_out == `LCS_SENSE_ZERO)
        else $error("sensing active during overcurrent window");
    a_reset_mode: assert property (disable iff (1'b0)
        !rst_n |=> !cfg_rdata.hold_mode && sense_valid_strobe_n && !sense_accurate)
        else $error("reset state wrong");
    a_ratio_trim: assert property (
        cfg_wr |=> ratio_low_sel == $past(cfg_wdata.ratio_low) &&
                   oc_threshold_low == {2{$past(cfg_wdata.ratio_low)}})
        else $error("ratio select not applied");
    a_settle_time: assert property (
        $past(r.state) == LCS_ST_SETTLE && r.state == LCS_ST_VALID |->
        $past(settle_age) == SETTLE_CYC && !sense_valid_strobe_n)
        else $error("strobe fell at wrong time");
    a_strobe_stays: assert property (
        r.state == LCS_ST_VALID ##0 s_steady_cur |=> !sense_valid_strobe_n)
        else $error("strobe rose while channel on");
    a_sync_off: assert property (
        s_valid_off ##0 !cfg_now.hold_mode |=>
        sense_out == `LCS_SENSE_ZERO && sense_valid_strobe_n ##1 sense_valid_strobe_n)
        else $error("sync mode off handling wrong");
    a_th_capture: assert property (
        s_valid_off ##0 cfg_now.hold_mode |=>
        r.state == LCS_ST_HOLD && sense_out == $past(live) && sense_valid_strobe_n)
        else $error("track-and-hold capture wrong");
    a_hold_stable: assert property (
        s_hold_two ##0 src != LCS_SRC_TEMP |-> $stable(sense_out))
        else $error("held value changed");
    a_accurate_edge: assert property (
        $rose(sense_accurate) && r.state != LCS_ST_HOLD |-> $fell(sense_valid_strobe_n))
        else $error("accuracy flagged before strobe fell");
    a_chan_change: assert property (
        is_cur && chg |=> r.state == LCS_ST_IDLE && sense_valid_strobe_n &&
                          r.held == `LCS_SENSE_ZERO)
        else $error("held value kept across channel change");
    a_ofs_add: assert property (
        s_steady_cur ##0 cfg_now.offset_polarity[ch] && !sum_chk[`LCS_SENSE_W] |=>
        sense_out == $past(sum_chk[`LCS_SENSE_W-1:0]))
        else $error("positive offset not added");
    a_ofs_sub: assert property (
        s_steady_cur ##0 !cfg_now.offset_polarity[ch] && raw >= `LCS_SENSE_W'(ofs) |=>
        sense_out == $past(raw) - `LCS_SENSE_W'($past(ofs)))
        else $error("negative offset not subtracted");

    // Track-and-hold turn-off and turn-on steps
    sequence s_th_off;
        s_valid_off ##0 cfg_now.hold_mode;
    endsequence
    sequence s_hold_resume;
        r.state == LCS_ST_HOLD ##0 cfg_now.hold_mode ##0 s_steady_cur;
    endsequence
    sequence s_strobe_up_two;
        $rose(sense_valid_strobe_n) && sense_accurate ##1 sense_valid_strobe_n;
    endsequence

    a_th_strobe: assert property (
        s_th_off |=> s_strobe_up_two)
        else $error("strobe not raised at track-and-hold capture");
    a_hold_resume: assert property (
        s_hold_resume |=> r.state == LCS_ST_SETTLE && !sense_accurate &&
                          sense_valid_strobe_n && sense_out == $past(live))
        else $error("held value still flagged after turn-on");
    a_sync_no_hold: assert property (
        !cfg_now.hold_mode |=> r.state != LCS_ST_HOLD)
        else $error("hold state entered in synchronous mode");
    a_oc_restart: assert property (
        is_cur && oc |=> r.state == LCS_ST_IDLE && !sense_accurate)
        else $error("overcurrent window did not restart settling");
    a_no_source: assert property (
        src == LCS_SRC_NONE |=> sense_out == `LCS_SENSE_ZERO && sense_valid_strobe_n &&
                                sense_src == LCS_SRC_NONE)
        else $error("output not idle with no source selected");
    a_fall_after_settle: assert property (
        $fell(sense_valid_strobe_n) |-> $past(r.state) == LCS_ST_SETTLE)
        else $error("strobe fell without a settling interval");
    a_settle_high: assert property (
        r.state == LCS_ST_SETTLE |-> sense_valid_strobe_n && !sense_accurate)
        else $error("strobe low before settling ended");

endmodule : lcs_sense_ctrl

`default_nettype wire

// *** tb/lcs_host_model.sv ***
`default_nettype none
`include "lcs_consts.svh"

module lcs_host_model
    import lcs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Sense pins seen by the host
    input wire logic [`LCS_SENSE_W-1:0] sense_out,
    input wire logic sense_valid_strobe_n,
    // Host results
    output logic [`LCS_SENSE_W-1:0] sample_avg,
    output logic [7:0] off_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic strobe_d;
    logic [`LCS_SENSE_W-1:0] s_new;
    logic [`LCS_SENSE_W-1:0] s_old;
    logic [`LCS_SENSE_W:0] sum;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            strobe_d <= 1'b1;
            s_new <= 10'h000;
            s_old <= 10'h000;
            off_count <= 8'h00;
        end else begin
            strobe_d <= sense_valid_strobe_n;
            // Keep the last two readings, one per strobe falling edge
            if (strobe_d && !sense_valid_strobe_n) begin
                s_old <= s_new;
                s_new <= sense_out;
            end
            // Rising strobe marks turn-off or an overcurrent window for the off-state check
            if (!strobe_d && sense_valid_strobe_n) begin
                off_count <= off_count + 8'h01;
            end
        end
    end

    assign sum = {1'b0, s_new} + {1'b0, s_old};
    assign sample_avg = sum[`LCS_SENSE_W:1];
endmodule : lcs_host_model

`default_nettype wire

// *** tb/lcs_sense_ctrl_bench.sv ***
`default_nettype none
`include "lcs_consts.svh"

module lcs_sense_ctrl_bench
    import lcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_wr = 1'b0;
    lcs_cfg_t cfg_wdata = '0;
    lcs_cfg_t cfg_rdata;
    logic [1:0] chan_on = 2'h0;
    logic [1:0] oc_window = 2'h0;
    logic [9:0] cur0 = 10'h000;
    logic [9:0] cur1 = 10'h000;
    logic [9:0] temp_code = 10'h000;
    logic [5:0] rand_ofs0 = 6'h00;
    logic [5:0] rand_ofs1 = 6'h00;
    logic [9:0] sense_out;
    lcs_src_t sense_src;
    logic sense_accurate;
    logic strobe_n;
    logic ratio_low_sel;
    logic [1:0] oc_threshold_low;
    logic [9:0] host_avg;
    logic [7:0] off_count;
    int fail_count = 0;
    int check_count = 0;

    lcs_sense_ctrl i_lcs_sense_ctrl (.core_clk(core_clk), .rst_n(rst_n), .cfg_wr(cfg_wr),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .chan_on(chan_on),
        .oc_window(oc_window), .cur0(cur0), .cur1(cur1), .temp_code(temp_code),
        .rand_ofs0(rand_ofs0), .rand_ofs1(rand_ofs1), .sense_out(sense_out),
        .sense_src(sense_src), .sense_accurate(sense_accurate),
        .sense_valid_strobe_n(strobe_n), .ratio_low_sel(ratio_low_sel),
        .oc_threshold_low(oc_threshold_low));
    lcs_host_model i_lcs_host_model (.core_clk(core_clk), .rst_n(rst_n),
        .sense_out(sense_out), .sense_valid_strobe_n(strobe_n),
        .sample_avg(host_avg), .off_count(off_count));

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    // Fields: {select1, select0, hold_mode, ratio_low, polarity[1:0]}
    task automatic wcfg(input lcs_cfg_t w);
        cfg_wr = 1'b1;
        cfg_wdata = w;
        step(1);
        cfg_wr = 1'b0;
        // One idle edge, so a following write never re-raises the strobe in the same step
        step(1);
    endtask : wcfg

    // Settling takes about 500 cycles; allow a margin
    task automatic wait_valid();
        int i;
        for (i = 0; i < 700 && strobe_n !== 1'b0; i++) step(1);
        if (i >= 700) begin
            fail_count++;
            print_verdict();
        end
    endtask : wait_valid

    task automatic t_reset();
        check(16'(cfg_rdata), 16'h0000);
        check(16'(strobe_n), 16'h0001);
        check(16'(sense_out), 16'h0000);
        check(16'(sense_src), 16'(LCS_SRC_NONE));
    endtask : t_reset

    task automatic t_sync();
        cur0 = 10'h064;
        rand_ofs0 = 6'h05;
        chan_on = 2'h1;
        wcfg(6'h11);
        wait_valid();
        check(16'(sense_out), 16'h0069);
        check(16'(sense_src), 16'(LCS_SRC_CH0));
        check(16'(sense_accurate), 16'h0001);
        oc_window = 2'h1;
        step(2);
        check(16'(strobe_n), 16'h0001);
        check(16'(sense_out), 16'h0000);
        oc_window = 2'h0;
        wait_valid();
        chan_on = 2'h0;
        step(2);
        check(16'(strobe_n), 16'h0001);
        check(16'(sense_out), 16'h0000);
        check(16'(off_count), 16'h0002);
        // Second reading with the opposite polarity cancels the offset
        wcfg(6'h10);
        chan_on = 2'h1;
        wait_valid();
        check(16'(sense_out), 16'h005F);
        step(1);
        check(16'(host_avg), 16'h0064);
        chan_on = 2'h0;
        step(2);
    endtask : t_sync

    task automatic t_ratio();
        wcfg(6'h04);
        check(16'(ratio_low_sel), 16'h0001);
        check(16'(oc_threshold_low), 16'h0003);
        wcfg(6'h00);
        check(16'(ratio_low_sel), 16'h0000);
        check(16'(oc_threshold_low), 16'h0000);
    endtask : t_ratio

    // Off time stays short, well above the minimum hold-mode rate
    task automatic t_hold();
        cur1 = 10'h0C8;
        rand_ofs1 = 6'h07;
        chan_on = 2'h2;
        wcfg(6'h28);
        step(2);
        check(16'(cfg_rdata), 16'h0028);
        check(16'(sense_accurate), 16'h0000);
        wait_valid();
        check(16'(sense_accurate), 16'h0001);
        check(16'(sense_src), 16'(LCS_SRC_CH1));
        chan_on = 2'h0;
        step(2);
        check(16'(strobe_n), 16'h0001);
        check(16'(sense_out), 16'h00C1);
        cur1 = 10'h032;
        wcfg(6'h2B);
        step(2);
        check(16'(sense_out), 16'h00C1);
        // Turn-on after a hold: the new reading counts only after the strobe falls
        chan_on = 2'h2;
        step(2);
        check(16'(sense_accurate), 16'h0000);
        check(16'(sense_out), 16'h0039);
        wait_valid();
        check(16'(sense_accurate), 16'h0001);
        chan_on = 2'h0;
        step(2);
        check(16'(sense_out), 16'h0039);
        check(16'(strobe_n), 16'h0001);
        wcfg(6'h18);
        step(2);
        check(16'(sense_out), 16'h0000);
        check(16'(sense_accurate), 16'h0000);
    endtask : t_hold

    task automatic t_temp();
        temp_code = 10'h155;
        wcfg(6'h30);
        step(2);
        check(16'(sense_out), 16'h0155);
        check(16'(sense_src), 16'(LCS_SRC_TEMP));
        check(16'(strobe_n), 16'h0001);
        check(16'(sense_accurate), 16'h0000);
    endtask : t_temp

    initial begin
        repeat (16) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_sync();
        t_ratio();
        t_hold();
        t_temp();
        print_verdict();
    end
endmodule : lcs_sense_ctrl_bench

`default_nettype wire
